// ---- design/dbp_consts.vh ----
/*
 Constants for the burst and precharge logic of a four-bank DDR2 device:
 register map, field positions, reset values, latency counter values and link bundle width.
 Assumes a 10 MHz system clock that oversamples the slower command clock.
*/
// Overview of operation
// - Burst length 4 or 8, sequential or interleaved
// - Sequential order wraps within each nibble
// - Interleaved order is start column XOR beat
// - No burst terminate command is decoded
// - Read decoded when chip, column strobes low
// - First read word after additive plus CAS latency
// - Read strobe low preamble, data on strobe edges
// - Strobe single-ended or differential by control bit
// - Write decoded when chip, column, write low
// - Write data on strobe edges, extra ignored
// - Mask per data byte, writes only
// - Precharge decoded when chip, row, write low
// - Address bit 10 high closes all banks
// - Address bit 10 on access selects auto-precharge
`ifndef DBP_CONSTS_VH
`define DBP_CONSTS_VH

// APB register byte addresses
`define DBP_ADDR_CTRL    12'h000
`define DBP_ADDR_STATUS  12'h004

// Control register fields
`define DBP_CTRL_BL      2:0
`define DBP_CTRL_BT      3
`define DBP_CTRL_CL      6:4
`define DBP_CTRL_AL      10:8
`define DBP_CTRL_DIFF    12
`define DBP_CTRL_RESET   32'h0000_1032
`define DBP_CTRL_MASK    32'h0000_177F

// Burst length codes
`define DBP_BL_4         3'h2
`define DBP_BL_8         3'h3
`define DBP_LAST_BL4     3'h3
`define DBP_LAST_BL8     3'h7

// Status register fields
`define DBP_STAT_BANKS   3:0
`define DBP_STAT_RD      4
`define DBP_STAT_WR      5

// Latency counter values
`define DBP_LAT_ZERO     4'h0
`define DBP_LAT_ONE      4'h1
`define DBP_LAT_TWO      4'h2

// Link input bundle width
`define DBP_SYNC_W       31

`endif

// ---- design/dbp_burst_seq.v ----
/*
 Burst column sequencer: maps start column and beat number to the column
 addressed in that beat. Purely combinational; caller holds its inputs.
*/
`timescale 1ns/1ns
module dbp_burst_seq
(
	input  wire [2:0] start_col,
	input  wire [2:0] beat,
	input  wire       bl8,
	input  wire       ileave,
	output reg  [2:0] col
);

	always @*
	begin
		if (ileave)
			col = start_col ^ (bl8 ? beat : {1'b0, beat[1:0]});
		else
			col = {start_col[2] ^ (bl8 & beat[2]), start_col[1:0] + beat[1:0]};
	end

endmodule // dbp_burst_seq

// ---- design/dbp_core.v ----
/*
 Burst read, burst write, write mask and precharge logic of a four-bank
 DDR2 device, with a small data array of 8 columns per bank.
 Assumes the command clock and all link pins are slow against ref_clk
 (at least four samples per half period) and are resynchronised here.
 Mode settings are reached over APB; pready is always high.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "dbp_consts.vh"
module dbp_core
(
	input  wire        ref_clk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        ck,
	input  wire        cs_n,
	input  wire        ras_n,
	input  wire        cas_n,
	input  wire        we_n,
	input  wire [13:0] addr,
	input  wire [1:0]  ba,
	input  wire        dm,
	input  wire [7:0]  dq_in,
	output wire [7:0]  dq_out,
	output wire        dq_oe,
	input  wire        dqs_in,
	output wire        dqs_out,
	output wire        dqs_oe,
	output wire        dqs_n_out,
	output wire        dqs_n_oe
);

	localparam R_IDLE  = 2'h0;
	localparam R_PRE   = 2'h1;
	localparam R_BURST = 2'h2;
	localparam W_IDLE  = 1'b0;
	localparam W_CAPT  = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Link input synchroniser
	reg  [`DBP_SYNC_W-1:0] sync1_reg;
	reg  [`DBP_SYNC_W-1:0] sync2_reg;
	reg                    ck_d_reg;
	reg                    dqs_d_reg;

	always @(posedge ref_clk)
	begin
		sync1_reg <= {ck, cs_n, ras_n, cas_n, we_n, addr, ba, dm, dq_in, dqs_in};
		sync2_reg <= sync1_reg;
		ck_d_reg  <= sync2_reg[30];
		dqs_d_reg <= sync2_reg[0];
	end

	wire        ck_s    = sync2_reg[30];
	wire        cs_s    = ~sync2_reg[29];
	wire        ras_s   = ~sync2_reg[28];
	wire        cas_s   = ~sync2_reg[27];
	wire        we_s    = ~sync2_reg[26];
	wire [13:0] addr_s  = sync2_reg[25:12];
	wire [1:0]  ba_s    = sync2_reg[11:10];
	wire        dm_s    = sync2_reg[9];
	wire [7:0]  dq_s    = sync2_reg[8:1];
	wire        dqs_s   = sync2_reg[0];
	wire        ck_rise = ck_s & ~ck_d_reg;
	wire        ck_fall = ~ck_s & ck_d_reg;
	wire        dqs_rise = dqs_s & ~dqs_d_reg;
	wire        dqs_fall = ~dqs_s & dqs_d_reg;

	// Command decode on command clock rising edges; the terminate pattern
	// (row and column strobes high, write low) is left undecoded
	wire cmd_act = ck_rise & cs_s & ras_s & ~cas_s & ~we_s;
	wire cmd_rd  = ck_rise & cs_s & ~ras_s & cas_s & ~we_s;
	wire cmd_wr  = ck_rise & cs_s & ~ras_s & cas_s & we_s;
	wire cmd_pre = ck_rise & cs_s & ras_s & ~cas_s & we_s;

	////////////////////////////////////////////////////////////////////////
	// APB registers
	reg  [31:0] ctrl_reg;
	reg  [31:0] prdata_reg;
	reg  [3:0]  bank_reg;
	reg  [3:0]  bank_next;
	reg  [1:0]  r_state_reg;
	reg         w_state_reg;
	reg         rd_pend_reg;
	reg         wr_pend_reg;

	wire addr_ok = (paddr == `DBP_ADDR_CTRL) | (paddr == `DBP_ADDR_STATUS);
	wire apb_wr  = psel & penable & pwrite & (paddr == `DBP_ADDR_CTRL);
	wire bl_ok   = (pwdata[`DBP_CTRL_BL] == `DBP_BL_4) | (pwdata[`DBP_CTRL_BL] == `DBP_BL_8);
	wire [31:0] status_word;

	assign status_word = {26'h0000000, w_state_reg | wr_pend_reg,
		(r_state_reg != R_IDLE) | rd_pend_reg, bank_reg};
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = prdata_reg;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ctrl_reg   <= `DBP_CTRL_RESET;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			if (apb_wr)
			begin
				ctrl_reg <= pwdata & `DBP_CTRL_MASK;
				if (!bl_ok)
					ctrl_reg[`DBP_CTRL_BL] <= ctrl_reg[`DBP_CTRL_BL];
			end
			if (psel & ~penable)
			begin
				if (paddr == `DBP_ADDR_CTRL)
					prdata_reg <= ctrl_reg;
				else if (paddr == `DBP_ADDR_STATUS)
					prdata_reg <= status_word;
				else
					prdata_reg <= 32'h0000_0000;
			end
		end
	end

	wire       bl8      = (ctrl_reg[`DBP_CTRL_BL] == `DBP_BL_8);
	wire       ileave   = ctrl_reg[`DBP_CTRL_BT];
	wire       diff_en  = ctrl_reg[`DBP_CTRL_DIFF];
	wire [3:0] rl       = {1'b0, ctrl_reg[`DBP_CTRL_CL]} + {1'b0, ctrl_reg[`DBP_CTRL_AL]};
	wire [3:0] wl       = rl - `DBP_LAT_ONE;
	wire [2:0] last_beat = bl8 ? `DBP_LAST_BL8 : `DBP_LAST_BL4;

	////////////////////////////////////////////////////////////////////////
	// Data array
	reg  [7:0] mem [0:31];
	////////////////////////////////////////////////////////////////////////
	// Read path
	reg  [3:0] rd_lat_reg;
	reg  [2:0] rd_pcol_reg;
	reg  [1:0] rd_pbank_reg;
	reg        rd_pap_reg;
	reg  [2:0] rd_col_reg;
	reg  [1:0] rd_bank_reg;
	reg        rd_ap_reg;
	reg  [2:0] rd_beat_reg;
	reg  [7:0] dq_out_reg;
	reg        dq_oe_reg;
	reg        dqs_out_reg;
	reg        dqs_oe_reg;
	wire rd_start = ck_rise & rd_pend_reg & (rd_lat_reg == `DBP_LAT_ONE);
	wire rd_prea  = ck_rise & rd_pend_reg & (rd_lat_reg == `DBP_LAT_TWO);
	wire rd_bst   = (r_state_reg == R_BURST);
	wire rd_last  = rd_bst & (rd_beat_reg == last_beat);
	wire rd_end   = ck_rise & rd_last;
	wire rd_step  = (ck_rise | ck_fall) & rd_bst & ~rd_last;
	wire [2:0] rs_col  = rd_start ? rd_pcol_reg : rd_col_reg;
	wire [2:0] rs_beat = rd_start ? 3'h0 : rd_beat_reg + 3'h1;
	wire [1:0] rs_bank = rd_start ? rd_pbank_reg : rd_bank_reg;
	wire [2:0] rd_seq_col;

	dbp_burst_seq u_rd_seq
	(
		.start_col (rs_col),
		.beat      (rs_beat),
		.bl8       (bl8),
		.ileave    (ileave),
		.col       (rd_seq_col)
	);

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rd_pend_reg <= 1'b0;
			rd_lat_reg  <= `DBP_LAT_ZERO;
			rd_pcol_reg <= 3'h0;
			rd_pbank_reg <= 2'h0;
			rd_pap_reg  <= 1'b0;
		end
		else if (cmd_rd)
		begin
			rd_pend_reg <= 1'b1;
			rd_lat_reg  <= rl;
			rd_pcol_reg <= addr_s[2:0];
			rd_pbank_reg <= ba_s;
			rd_pap_reg  <= addr_s[10];
		end
		else if (ck_rise & rd_pend_reg)
		begin
			rd_lat_reg <= rd_lat_reg - `DBP_LAT_ONE;
			if (rd_lat_reg == `DBP_LAT_ONE)
				rd_pend_reg <= 1'b0;
		end
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			r_state_reg <= R_IDLE;
			rd_col_reg  <= 3'h0;
			rd_bank_reg <= 2'h0;
			rd_ap_reg   <= 1'b0;
			rd_beat_reg <= 3'h0;
			dq_out_reg  <= 8'h00;
			dq_oe_reg   <= 1'b0;
			dqs_out_reg <= 1'b0;
			dqs_oe_reg  <= 1'b0;
		end
		else if (rd_start)
		begin
			// First word with the first rising strobe edge; seamless bursts land here too
			r_state_reg <= R_BURST;
			rd_col_reg  <= rd_pcol_reg;
			rd_bank_reg <= rd_pbank_reg;
			rd_ap_reg   <= rd_pap_reg;
			rd_beat_reg <= 3'h0;
			dq_out_reg  <= mem[{rs_bank, rd_seq_col}];
			dq_oe_reg   <= 1'b1;
			dqs_out_reg <= 1'b1;
			dqs_oe_reg  <= 1'b1;
		end
		else if (rd_step)
		begin
			rd_beat_reg <= rs_beat;
			dq_out_reg  <= mem[{rs_bank, rd_seq_col}];
			dqs_out_reg <= ck_rise;
		end
		else if (rd_end | rd_prea)
		begin
			// Preamble: strobe driven low one command clock before data
			r_state_reg <= rd_prea ? R_PRE : R_IDLE;
			dq_oe_reg   <= 1'b0;
			dqs_out_reg <= 1'b0;
			dqs_oe_reg  <= rd_prea;
		end
	end

	assign dq_out    = dq_out_reg;
	assign dq_oe     = dq_oe_reg;
	assign dqs_out   = dqs_out_reg;
	assign dqs_oe    = dqs_oe_reg;
	assign dqs_n_out = ~dqs_out_reg;
	assign dqs_n_oe  = dqs_oe_reg & diff_en;

	////////////////////////////////////////////////////////////////////////
	// Write path
	reg  [3:0] wr_lat_reg;
	reg  [2:0] wr_pcol_reg;
	reg  [1:0] wr_pbank_reg;
	reg        wr_pap_reg;
	reg  [2:0] wr_col_reg;
	reg  [1:0] wr_bank_reg;
	reg        wr_ap_reg;
	reg  [2:0] wr_beat_reg;
	reg        wr_started_reg;
	wire wr_arm  = (cmd_wr & (wl == `DBP_LAT_ZERO)) |
		(ck_rise & wr_pend_reg & ~cmd_wr & (wr_lat_reg == `DBP_LAT_ONE));
	wire wr_edge = (w_state_reg == W_CAPT) & (dqs_rise | (wr_started_reg & dqs_fall));
	wire wr_end  = wr_edge & (wr_beat_reg == last_beat);
	wire [2:0] wr_seq_col;

	dbp_burst_seq u_wr_seq
	(
		.start_col (wr_col_reg),
		.beat      (wr_beat_reg),
		.bl8       (bl8),
		.ileave    (ileave),
		.col       (wr_seq_col)
	);

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_pend_reg  <= 1'b0;
			wr_lat_reg   <= `DBP_LAT_ZERO;
			wr_pcol_reg  <= 3'h0;
			wr_pbank_reg <= 2'h0;
			wr_pap_reg   <= 1'b0;
		end
		else if (cmd_wr)
		begin
			wr_pend_reg  <= (wl != `DBP_LAT_ZERO);
			wr_lat_reg   <= wl;
			wr_pcol_reg  <= addr_s[2:0];
			wr_pbank_reg <= ba_s;
			wr_pap_reg   <= addr_s[10];
		end
		else if (ck_rise & wr_pend_reg)
		begin
			wr_lat_reg <= wr_lat_reg - `DBP_LAT_ONE;
			if (wr_lat_reg == `DBP_LAT_ONE)
				wr_pend_reg <= 1'b0;
		end
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			w_state_reg    <= W_IDLE;
			wr_col_reg     <= 3'h0;
			wr_bank_reg    <= 2'h0;
			wr_ap_reg      <= 1'b0;
			wr_beat_reg    <= 3'h0;
			wr_started_reg <= 1'b0;
		end
		else if (wr_arm)
		begin
			w_state_reg    <= W_CAPT;
			wr_col_reg     <= cmd_wr ? addr_s[2:0] : wr_pcol_reg;
			wr_bank_reg    <= cmd_wr ? ba_s : wr_pbank_reg;
			wr_ap_reg      <= cmd_wr ? addr_s[10] : wr_pap_reg;
			wr_beat_reg    <= 3'h0;
			wr_started_reg <= 1'b0;
		end
		else if (wr_edge)
		begin
			// Past the last beat the capture closes and further data is ignored
			w_state_reg    <= wr_end ? W_IDLE : W_CAPT;
			wr_beat_reg    <= wr_beat_reg + 3'h1;
			wr_started_reg <= 1'b1;
		end
	end

	// Masked bytes leave the array untouched; mask is never looked at on reads
	always @(posedge ref_clk)
	begin
		if (wr_edge & ~dm_s)
			mem[{wr_bank_reg, wr_seq_col}] <= dq_s;
	end

	////////////////////////////////////////////////////////////////////////
	// Bank state
	// Spacing from access to precharge is the controller's duty; no check here
	always @*
	begin
		bank_next = bank_reg;
		if (rd_end & rd_ap_reg)
			bank_next[rd_bank_reg] = 1'b0;
		if (wr_end & wr_ap_reg)
			bank_next[wr_bank_reg] = 1'b0;
		if (cmd_pre)
		begin
			if (addr_s[10])
				bank_next = 4'h0;
			else
				bank_next[ba_s] = 1'b0;
		end
		if (cmd_act)
			bank_next[ba_s] = 1'b1;
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			bank_reg <= 4'h0;
		else
			bank_reg <= bank_next;
	end

endmodule // dbp_core

// ---- verification/dbp_core_assertions.sv ----
/*
 Port checks for dbp_core.
 Assumes it is bound into dbp_core.
*/
`timescale 1ns/1ns
module dbp_chk
(
	input logic        ref_clk,
	input logic        sys_rst,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic        pslverr,
	input logic [7:0]  dq_out,
	input logic        dq_oe,
	input logic        dqs_out,
	input logic        dqs_oe,
	input logic        dqs_n_out,
	input logic        dqs_n_oe
);
	logic diff_reg;

	// Shadow of the differential strobe control bit
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			diff_reg <= 1'b1;
		else if (psel && penable && pwrite && paddr == 12'h000)
			diff_reg <= pwdata[12];
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence pre_s;
		dqs_oe && !dqs_out;
	endsequence
	sequence word_s;
		dq_oe && dqs_out;
	endsequence

	////////////////////
	slverr_map_a: assert property (psel && penable |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
		else $error("pslverr wrong");
	strobe_compl_a: assert property (dqs_n_out == !dqs_out)
		else $error("strobe complement wrong");
	compl_enable_a: assert property (dqs_n_oe == (dqs_oe && diff_reg))
		else $error("complement enable wrong");
	read_preamble_a: assert property ($rose(dqs_oe) |-> pre_s [*8] ##1 word_s)
		else $error("read preamble wrong");
	data_strobe_a: assert property (dq_oe |-> dqs_oe)
		else $error("data without strobe");
	data_edge_a: assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(dqs_out))
		else $error("data off strobe edge");
	strobe_stride_a: assert property ($rose(dqs_out) && dq_oe |=> $stable(dqs_out) [*3] ##1 $fell(dqs_out))
		else $error("strobe spacing wrong");
	reset_idle_a: assert property ($fell(sys_rst) |-> !dq_oe && !dqs_oe && !dqs_n_oe)
		else $error("drive after reset");
endmodule // dbp_chk

bind dbp_core dbp_chk chk (.*);

// ---- verification/dbp_ctrl_model.sv ----
/*
 Memory controller model on the link pins of dbp_core.
 Assumes ref_clk runs eight times the command clock.
*/
`timescale 1ns/1ns
module dbp_ctrl_model
(
	input  logic        ref_clk,
	output logic        ck,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [13:0] addr,
	output logic [1:0]  ba,
	output logic        dm,
	output logic [7:0]  dq_in,
	output logic        dqs_in,
	input  logic [7:0]  dq_out,
	input  logic        dq_oe,
	input  logic        dqs_out
);
	logic [7:0] rq[$];
	logic       dqs_prev;
	int         qi;
	int         fq;

	initial
	begin
		{ck, cs_n, ras_n, cas_n, we_n, dm, dqs_in} = 7'h3C;
		{addr, ba, dq_in} = 24'h0;
	end

	////////////////////
	// Read bytes are taken on each strobe edge
	always @(posedge ref_clk)
	begin
		dqs_prev <= dqs_out;
		if (dq_oe === 1'b1 && dqs_out !== dqs_prev)
		begin
			if (rq.size() == 0)
				fq <= qi;
			rq.push_back(dq_out);
		end
	end

	// One command, then the clock runs nq quarter periods
	task automatic xfer(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input int nq,
		input int wl, input int nb, input logic [63:0] d, input logic [7:0] m);
		int j;
		begin
			{cs_n, ras_n, cas_n, we_n} <= c;
			ba <= b;
			addr <= a;
			dqs_in <= 1'b0;
			dm <= (nb == 0);
			for (qi = 0; qi < nq; qi++)
			begin
				repeat (2) @(posedge ref_clk);
				j = qi / 2 - 2 * wl;
				if (qi % 2 == 0)
					ck <= ~ck;
				if (qi == 2)
					cs_n <= 1'b1;
				if (nb > 0 && j >= 0 && j < nb + 2)
				begin
					if (qi % 2 == 0)
					begin
						dq_in <= (j < nb) ? d[8 * j +: 8] : 8'hEE;
						dm <= (j < nb) && m[j];
					end
					else
						dqs_in <= ~dqs_in;
				end
			end
			dq_in <= ~dq_in;
			dqs_in <= ~dqs_in;
			@(posedge ref_clk);
		end
	endtask
endmodule // dbp_ctrl_model

// ---- verification/dbp_core_tb_top.sv ----
/*
 Self-checking bench for dbp_core.
 Assumes the controller model and the bound checker.
*/
`timescale 1ns/1ns
module dbp_core_tb_top;
	logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
	logic        ck, cs_n, ras_n, cas_n, we_n, dm, dq_oe, dqs_in, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] addr;
	logic [1:0]  ba;
	logic [7:0]  dq_in, dq_out;
	int          n_errors, n_compared, i, j, c;

	dbp_core uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ck, .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .dm, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out,
		.dqs_oe, .dqs_n_out, .dqs_n_oe);
	dbp_ctrl_model pm (.ref_clk, .ck, .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .dm, .dq_in, .dqs_in,
		.dq_out, .dq_oe, .dqs_out);

	always #50 ref_clk = ~ref_clk;

	task summarize;
		begin
			if (n_errors == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_compared++;
			if (got !== exp)
			begin
				n_errors++;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge ref_clk);
			penable <= 1'b1;
			k = 0;
			do
			begin
				@(posedge ref_clk);
				k++;
			end
			while (pready !== 1'b1 && k < 16);
			if (pready !== 1'b1)
			begin
				n_errors++;
				summarize();
			end
			rd = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
		end
	endtask

	task st(input logic [31:0] exp);
		begin
			apb(1'b0, 12'h004, 32'h0);
			chk(rd, exp);
		end
	endtask

	////////////////////
	initial
	begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = 47'h0;
		n_errors = 0;
		n_compared = 0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		// Register map, read-only status, unmapped place, refused length code
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_1032);
		apb(1'b1, 12'h004, 32'h0000_003F);
		st(32'h0);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		chk(e, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_177A);
		// Write, masked rewrite and read at two latencies
		pm.xfer(4'h3, 2'h1, 14'h0, 8, 0, 0, 64'h0, 8'h0);
		st(32'h2);
		for (i = 0; i < 2; i++)
		begin
			c = 3 + i;
			apb(1'b1, 12'h000, i ? 32'h0000_0222 : 32'h0000_0032);
			pm.xfer(4'h4, 2'h1, 14'h0, 4 * c + 20, c - 1, 4, 64'hD4C3_B2A1, 8'h0);
			pm.xfer(4'h4, 2'h1, 14'h0, 4 * c + 20, c - 1, 4, 64'h4433_2211, 8'h4);
			pm.rq.delete();
			pm.xfer(4'h5, 2'h1, 14'h1, 4 * c + 20, 0, 0, 64'h0, 8'h0);
			chk(pm.fq / 4, c);
			chk(pm.rq.size(), 4);
			for (j = 0; j < 4; j++)
				chk(pm.rq[j], (32'h1144_C322 >> (8 * j)) & 32'hFF);
		end
		// Length 8 interleaved then sequential, auto-precharge at the end
		pm.xfer(4'h3, 2'h2, 14'h0, 8, 0, 0, 64'h0, 8'h0);
		for (i = 0; i < 2; i++)
		begin
			apb(1'b1, 12'h000, i ? 32'h0000_1033 : 32'h0000_103B);
			pm.xfer(4'h4, 2'h2, 14'h0, 40, 2, 8, 64'h8877_6655_4433_2211, 8'h0);
			pm.rq.delete();
			pm.xfer(4'h5, 2'h2, i ? 14'h405 : 14'h5, 40, 0, 0, 64'h0, 8'h0);
			chk(pm.rq.size(), 8);
			for (j = 0; j < 8; j++)
			begin
				c = i ? (((j & 4) ^ 4) | ((j + 1) & 3)) : (5 ^ j);
				chk(pm.rq[j], (c + 1) * 32'h11);
			end
		end
		st(32'h2);
		// Single-bank and all-bank precharge
		pm.xfer(4'h3, 2'h0, 14'h0, 8, 0, 0, 64'h0, 8'h0);
		pm.xfer(4'h3, 2'h3, 14'h0, 8, 0, 0, 64'h0, 8'h0);
		st(32'hB);
		pm.xfer(4'h2, 2'h3, 14'h0, 8, 0, 0, 64'h0, 8'h0);
		st(32'h3);
		pm.xfer(4'h2, 2'h0, 14'h400, 8, 0, 0, 64'h0, 8'h0);
		st(32'h0);
		summarize();
	end
endmodule // dbp_core_tb_top
